// [include/alo_defs.vh]
// constants for the accumulator load instruction group
`ifndef ALO_DEFS_VH
`define ALO_DEFS_VH
`define ALO_OP_WIDTH        4
`define ALO_OP_NONE         4'h0
`define ALO_OP_WAKE0        4'h1
`define ALO_OP_WAKE1        4'h2
`define ALO_OP_WAKE2        4'h3
`define ALO_OP_CONV_LOW     4'h4
`define ALO_OP_MEMORY       4'h5
`define ALO_OP_CLOCK_CTRL   4'h6
`define ALO_OP_CONV_CTRL    4'h7
`define ALO_OP_STACK_PTR    4'h8
`define ALO_ACC_RESET       4'h0
`define ALO_FILE_RESET      4'h0
`define ALO_CYCLES_PER_OP   1
`endif

// [design/alo_load_ops.v]
// accumulator load instruction group execution logic
// Operation
// - The first wakeup read copies wakeup control zero into all four accumulator bits.
// - The second wakeup read copies wakeup control one into the accumulator.
// - The third wakeup read copies wakeup control two into the accumulator.
// - Conversion-low read puts result bits 1:0 in accumulator 3:2 and zeros 1:0.
// - Memory load copies the nibble at the memory pointer and xors the file selector.
// - Clock-control read copies the clock control register into the accumulator.
// - Conversion-control read copies the conversion control register into it.
// - Stack-pointer read puts the pointer in bits 2:0 and zero in bit 3.
`timescale 1ns/10ps
`include "alo_defs.vh"

module alo_load_ops #(
    parameter DATA_WIDTH = 4,
    parameter SP_WIDTH   = 3
) (
    // clock and reset
    input  wire                    ref_clk,
    input  wire                    arst_n,
    // decoded instruction
    input  wire                    op_valid,
    input  wire [3:0]              op_code,
    input  wire [3:0]              imm_value,
    // sources
    input  wire [DATA_WIDTH-1:0]   wakeup_control_zero,
    input  wire [DATA_WIDTH-1:0]   wakeup_control_one,
    input  wire [DATA_WIDTH-1:0]   wakeup_control_two,
    input  wire [1:0]              conv_result_low,
    input  wire [DATA_WIDTH-1:0]   mem_data,
    input  wire [DATA_WIDTH-1:0]   clock_control_reg,
    input  wire [DATA_WIDTH-1:0]   conversion_control_reg,
    input  wire [SP_WIDTH-1:0]     stack_pointer,
    input  wire                    carry_in,
    // results
    output reg  [DATA_WIDTH-1:0]   acc,
    output reg  [3:0]              ram_file_sel,
    output reg                     carry,
    output reg                     skip_next,
    output reg                     op_done
);

    // op codes of this group
    localparam [3:0] OP_WAKE0      = `ALO_OP_WAKE0;
    localparam [3:0] OP_WAKE1      = `ALO_OP_WAKE1;
    localparam [3:0] OP_WAKE2      = `ALO_OP_WAKE2;
    localparam [3:0] OP_CONV_LOW   = `ALO_OP_CONV_LOW;
    localparam [3:0] OP_MEMORY     = `ALO_OP_MEMORY;
    localparam [3:0] OP_CLOCK_CTRL = `ALO_OP_CLOCK_CTRL;
    localparam [3:0] OP_CONV_CTRL  = `ALO_OP_CONV_CTRL;
    localparam [3:0] OP_STACK_PTR  = `ALO_OP_STACK_PTR;

    // next values
    reg  [DATA_WIDTH-1:0] next_acc;
    reg  [3:0]            next_file;
    reg                   next_carry;
    reg                   next_skip;
    reg                   next_done;

    // one select line per op
    wire                  sel_wake0;
    wire                  sel_wake1;
    wire                  sel_wake2;
    wire                  sel_conv_low;
    wire                  sel_memory;
    wire                  sel_clock_ctrl;
    wire                  sel_conv_ctrl;
    wire                  sel_stack_ptr;
    wire                  group_hit;

    // true for any code of this group
    function is_group_op;
        input [3:0] code;
        begin
            case (code)
                OP_WAKE0:      is_group_op = 1'b1;
                OP_WAKE1:      is_group_op = 1'b1;
                OP_WAKE2:      is_group_op = 1'b1;
                OP_CONV_LOW:   is_group_op = 1'b1;
                OP_MEMORY:     is_group_op = 1'b1;
                OP_CLOCK_CTRL: is_group_op = 1'b1;
                OP_CONV_CTRL:  is_group_op = 1'b1;
                OP_STACK_PTR:  is_group_op = 1'b1;
                default:       is_group_op = 1'b0;
            endcase
        end
    endfunction

    // valid op with the wanted code
    function match_op;
        input       valid;
        input [3:0] code;
        input [3:0] want;
        begin
            match_op = valid && (code == want);
        end
    endfunction

    // result bits 1:0 land in acc 3:2
    function [DATA_WIDTH-1:0] pack_conv_low;
        input [1:0] res;
        begin
            pack_conv_low      = {DATA_WIDTH{1'b0}};
            pack_conv_low[3:2] = res;
        end
    endfunction

    // pointer in the low bits, top bit cleared
    function [DATA_WIDTH-1:0] pack_stack_ptr;
        input [SP_WIDTH-1:0] sp;
        begin
            pack_stack_ptr               = {DATA_WIDTH{1'b0}};
            pack_stack_ptr[SP_WIDTH-1:0] = sp;
        end
    endfunction

    assign sel_wake0      = match_op(op_valid, op_code, OP_WAKE0);
    assign sel_wake1      = match_op(op_valid, op_code, OP_WAKE1);
    assign sel_wake2      = match_op(op_valid, op_code, OP_WAKE2);
    assign sel_conv_low   = match_op(op_valid, op_code, OP_CONV_LOW);
    assign sel_memory     = match_op(op_valid, op_code, OP_MEMORY);
    assign sel_clock_ctrl = match_op(op_valid, op_code, OP_CLOCK_CTRL);
    assign sel_conv_ctrl  = match_op(op_valid, op_code, OP_CONV_CTRL);
    assign sel_stack_ptr  = match_op(op_valid, op_code, OP_STACK_PTR);
    assign group_hit      = op_valid && is_group_op(op_code);

    // accumulator source select; holds when idle
    always @* begin
        next_acc = acc;
        if (sel_wake0) begin
            next_acc = wakeup_control_zero;
        end else if (sel_wake1) begin
            next_acc = wakeup_control_one;
        end else if (sel_wake2) begin
            next_acc = wakeup_control_two;
        end else if (sel_conv_low) begin
            next_acc = pack_conv_low(conv_result_low);
        end else if (sel_memory) begin
            next_acc = mem_data;
        end else if (sel_clock_ctrl) begin
            next_acc = clock_control_reg;
        end else if (sel_conv_ctrl) begin
            next_acc = conversion_control_reg;
        end else if (sel_stack_ptr) begin
            next_acc = pack_stack_ptr(stack_pointer);
        end
    end

    // file selector changes only on a memory load
    always @* begin
        next_file = ram_file_sel;
        if (sel_memory) begin
            next_file = ram_file_sel ^ imm_value;
        end
    end

    // carry passes through, no skip ever
    always @* begin
        next_carry = carry_in;
        next_skip  = 1'b0;
        next_done  = group_hit;
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc <= `ALO_ACC_RESET;
        end else begin
            acc <= next_acc;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ram_file_sel <= `ALO_FILE_RESET;
        end else begin
            ram_file_sel <= next_file;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            carry <= 1'b0;
        end else begin
            carry <= next_carry;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            skip_next <= 1'b0;
        end else begin
            skip_next <= next_skip;
        end
    end

    // one-cycle pulse per executed op
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            op_done <= 1'b0;
        end else begin
            op_done <= next_done;
        end
    end

endmodule

// [bench/alo_load_ops_assertions.sv]
// assertions for the accumulator load group
`timescale 1ns/10ps
module alo_chk (
    // clock and reset
    input wire       ref_clk,
    input wire       arst_n,
    // decoded instruction
    input wire       op_valid,
    input wire [3:0] op_code,
    input wire [3:0] imm_value,
    // sources
    input wire [3:0] wakeup_control_zero,
    input wire [3:0] wakeup_control_one,
    input wire [3:0] wakeup_control_two,
    input wire [1:0] conv_result_low,
    input wire [3:0] mem_data,
    input wire [3:0] clock_control_reg,
    input wire [3:0] conversion_control_reg,
    input wire [2:0] stack_pointer,
    input wire       carry_in,
    // results
    input wire [3:0] acc,
    input wire [3:0] ram_file_sel,
    input wire       carry,
    input wire       skip_next,
    input wire       op_done
);
wire [3:0] q = op_valid ? op_code : 4'h0;
default clocking @(posedge ref_clk); endclocking
default disable iff (!arst_n);
wk_zero_a: assert property(q==1|=>acc==$past(wakeup_control_zero))else $error("acc");
wk_one_a: assert property(q==2|=>acc==$past(wakeup_control_one))else $error("acc");
wk_two_a: assert property(q==3|=>acc==$past(wakeup_control_two))else $error("acc");
conv_lo_a: assert property(q==4|=>acc=={$past(conv_result_low),2'h0})else $error("acc");
mem_rd_a: assert property(q==5|=>acc==$past(mem_data)&&
ram_file_sel==$past(ram_file_sel^imm_value))else $error("mem");
clk_rd_a: assert property(q==6|=>acc==$past(clock_control_reg))else $error("acc");
adc_rd_a: assert property(q==7|=>acc==$past(conversion_control_reg))else $error("acc");
stk_rd_a: assert property(q==8|=>acc=={1'b0,$past(stack_pointer)})else $error("acc");
carry_keep_a: assert property($past(arst_n)|->carry==$past(carry_in))
else $error("carry");
no_skip_a: assert property(skip_next==1'b0)else $error("skip");
done_pulse_a: assert property($past(arst_n)|->op_done==$past(q!=4'h0&&q<4'h9))
else $error("done");
endmodule

// [bench/alo_load_ops_tb.sv]
// bench for the accumulator load group
`timescale 1ns/10ps
`include "alo_defs.vh"
module alo_load_ops_tb;
reg ref_clk=1'b0,arst_n=1'b0,op_valid=1'b0,carry_in=1'b0;
reg [3:0] op_code=4'h0,imm_value=4'h3,mem_data=4'ha,clock_control_reg=4'h6;
reg [3:0] conversion_control_reg=4'h9,wakeup_control_zero=4'hf;
reg [3:0] wakeup_control_one=4'h2,wakeup_control_two=4'h4;
reg [1:0] conv_result_low=2'h3;
reg [2:0] stack_pointer=3'h7;
wire [3:0] acc,ram_file_sel;
wire carry,skip_next,op_done;
int errors=0,checks_done=0;
alo_load_ops alo_load_ops_i(.ref_clk(ref_clk),.arst_n(arst_n),.op_valid(op_valid),
.op_code(op_code),.imm_value(imm_value),.wakeup_control_zero(wakeup_control_zero),
.wakeup_control_one(wakeup_control_one),.wakeup_control_two(wakeup_control_two),
.conv_result_low(conv_result_low),.mem_data(mem_data),.clock_control_reg(clock_control_reg),
.conversion_control_reg(conversion_control_reg),.stack_pointer(stack_pointer),
.carry_in(carry_in),.acc(acc),.ram_file_sel(ram_file_sel),.carry(carry),
.skip_next(skip_next),.op_done(op_done));
always #5 ref_clk=~ref_clk;
task check(input [15:0] seen,input [15:0] expected);
checks_done=checks_done+1;
if(seen!==expected)begin
errors=errors+1;
$display("mismatch %0t seen %h expected %h",$time,seen,expected);
end
endtask
// drive at one edge, executed at the next, judged just after it
task op(input v,input [3:0] c,input [3:0] e,input [3:0] f);
reg done_exp;
done_exp=v&&(c>=4'h1)&&(c<=4'h8);
@(posedge ref_clk);
op_valid<=v;
op_code<=c;
carry_in<=c[0];
@(posedge ref_clk);
op_valid<=1'b0;
#1;
check({8'h00,acc,ram_file_sel},{8'h00,e,f});
check({13'h0000,carry,skip_next,op_done},{13'h0000,c[0],1'b0,done_exp});
endtask
task all_ops;
op(1,1,15,0);op(1,2,2,0);op(1,3,4,0);
op(1,4,12,0);op(1,5,10,3);op(1,5,10,0);
op(1,6,6,0);op(1,7,9,0);op(1,8,7,0);op(0,5,7,0);op(1,15,7,0);
endtask
// reset in mid-run clears everything, then ops resume
task reset_mid;
@(posedge ref_clk);
arst_n<=1'b0;
#1;
check({8'h00,acc,ram_file_sel},{8'h00,`ALO_ACC_RESET,`ALO_FILE_RESET});
check({13'h0000,carry,skip_next,op_done},16'h0000);
repeat(2) @(posedge ref_clk);
arst_n<=1'b1;
op(1,5,10,3);
endtask
task complete_run;
$display("errors %0d checks %0d",errors,checks_done);
if(errors==0&&checks_done>0)$display("TEST PASSED");
else $display("TEST FAILED");
$finish;
endtask
initial begin
repeat(10) @(posedge ref_clk);
arst_n<=1'b1;
all_ops;
reset_mid;
complete_run;
end
endmodule
bind alo_load_ops alo_chk alo_chk_i(.ref_clk(ref_clk),.arst_n(arst_n),.op_valid(op_valid),
.op_code(op_code),.imm_value(imm_value),.wakeup_control_zero(wakeup_control_zero),
.wakeup_control_one(wakeup_control_one),.wakeup_control_two(wakeup_control_two),
.conv_result_low(conv_result_low),.mem_data(mem_data),.clock_control_reg(clock_control_reg),
.conversion_control_reg(conversion_control_reg),.stack_pointer(stack_pointer),
.carry_in(carry_in),.acc(acc),.ram_file_sel(ram_file_sel),.carry(carry),
.skip_next(skip_next),.op_done(op_done));
